// >>> common/aed_pkg.sv
// shared register map, field positions and reset values for the event debounce block
package aed_pkg;

    // ****************************************************************
    // data widths
    // ****************************************************************
    localparam int AED_REG_W    = 8;    // register byte width
    localparam int AED_ADDR_W   = 8;    // register address width
    localparam int AED_AXIS_W   = 14;   // signed accelerometer sample width
    localparam int AED_THS_W    = 13;   // unsigned magnitude threshold width
    localparam int AED_CNT_W    = 8;    // debounce count width
    localparam int AED_SUM_W    = 32;   // sum of three squared differences

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0] AED_ADDR_INT_SOURCE = 8'h0c;  // read clears latched flag
    localparam logic [7:0] AED_ADDR_FFMT_COUNT = 8'h18;  // freefall/motion debounce count
    localparam logic [7:0] AED_ADDR_VECM_CFG   = 8'h5f;  // magnitude change config
    localparam logic [7:0] AED_ADDR_VECM_THS_H = 8'h60;  // clear mode and threshold msbs
    localparam logic [7:0] AED_ADDR_VECM_THS_L = 8'h61;  // threshold lsbs
    localparam logic [7:0] AED_ADDR_VECM_CNT   = 8'h62;  // magnitude debounce count
    localparam logic [7:0] AED_ADDR_INITX_H    = 8'h63;  // initial x reference msbs
    localparam logic [7:0] AED_ADDR_INITX_L    = 8'h64;
    localparam logic [7:0] AED_ADDR_INITY_H    = 8'h65;
    localparam logic [7:0] AED_ADDR_INITY_L    = 8'h66;
    localparam logic [7:0] AED_ADDR_INITZ_H    = 8'h67;
    localparam logic [7:0] AED_ADDR_INITZ_L    = 8'h68;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int AED_CFG_ELE_BIT   = 6;  // latch enable
    localparam int AED_CFG_INITM_BIT = 5;  // reference init source
    localparam int AED_CFG_UPDM_BIT  = 4;  // reference update mode
    localparam int AED_CFG_EN_BIT    = 3;  // function enable
    localparam int AED_THS_DBCNTM_BIT = 7; // magnitude counter clear mode
    localparam logic [7:0] AED_CFG_MASK    = 8'h78;  // writable cfg bits
    localparam logic [7:0] AED_THS_H_MASK  = 8'h9f;  // clear mode plus threshold[12:8]
    localparam logic [7:0] AED_INIT_H_MASK = 8'h3f;  // initial value [13:8]

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] AED_RST_BYTE = 8'h00;  // every register resets to zero
    localparam logic [7:0] AED_RD_UNMAPPED = 8'h00;  // answer to any other address

    // ****************************************************************
    // sample step: one output sample period per count
    // ****************************************************************
    localparam int AED_STEP_800HZ_US = 1250;  // time step at 800 Hz
    localparam int AED_STEP_400HZ_US = 2500;  // time step at 400 Hz

endpackage : aed_pkg

// >>> verilog/aed_debounce_counter.sv
// saturating debounce counter with clear or decrement recovery and a hysteretic active flag
module aed_debounce_counter #(
    parameter int CNT_W = 8  // counter and limit width
) (
    input  wire logic             i_clk_sys,    // system clock
    input  wire logic             i_reset,      // synchronous reset, active high
    input  wire logic             i_step,       // one debounce time step
    input  wire logic             i_hold_clear, // forces counter and flag to zero
    input  wire logic             i_cond,       // event condition at this sample
    input  wire logic             i_clear_mode, // 1: clear on false, 0: decrement
    input  wire logic [CNT_W-1:0] i_limit,      // programmed debounce count
    output logic      [CNT_W-1:0] o_count,      // current count
    output logic                  o_active      // debounced event level
);

    logic [CNT_W-1:0] next_count;  // count after this step

    // ****************************************************************
    // next count
    // ****************************************************************
    // while the condition holds, a lowered limit pulls a larger count straight down to it
    always_comb
    begin
        if (i_cond)
        begin
            if (o_count < i_limit)
                next_count = o_count + 1'b1;
            else
                next_count = i_limit;
        end
        else if (i_clear_mode)
            next_count = '0;
        else if (o_count != '0)
            next_count = o_count - 1'b1;
        else
            next_count = '0;
    end

    // ****************************************************************
    // count register, updated only on a step, zeroed at once by hold clear
    // ****************************************************************
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset || i_hold_clear)
            o_count <= '0;
        else if (i_step)
            o_count <= next_count;
    end

    // ****************************************************************
    // active flag: set on reaching the limit, cleared on decay to zero
    // ****************************************************************
    // the count governs both edges, so in decrement mode short dropouts do not clear the flag
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset || i_hold_clear)
            o_active <= 1'b0;
        else if (i_step)
        begin
            if (i_cond && next_count == i_limit)
                o_active <= 1'b1;
            else if (next_count == '0 && !i_cond)
                o_active <= 1'b0;
        end
    end

endmodule : aed_debounce_counter

// >>> verilog/aed_event_debounce.sv
// freefall/motion debounce stage and vector-magnitude change function
//
// What this block does
// - set freefall/motion flag when count reaches limit
// - freefall/motion counter saturates at programmed count
// - one count lasts one output sample period
// - hybrid mode halves rate, doubling each step
// - clear mode: zero counter, else decrement
// - flag when distance exceeds threshold past debounce
// - magnitude threshold is 13-bit unsigned
// - magnitude debounce equals count times sample period
// - magnitude counter decrements or clears below threshold
// - reference values never readable by host
// - unlatched flag follows debounced condition both ways
// - latched flag held until source register read
// - reference from current data or init registers
// - update mode 0 reloads reference on trigger
// - update mode 1 keeps enable-time reference
// - both bits set: init writes act immediately
// - enable bit starts function, resets disabled
module aed_event_debounce
    import aed_pkg::*;
(
    input  wire logic                        i_clk_sys,        // 100 MHz system clock
    input  wire logic                        i_reset,          // synchronous, active high
    input  wire logic [aed_pkg::AED_ADDR_W-1:0] i_reg_addr,    // register address
    input  wire logic [aed_pkg::AED_REG_W-1:0]  i_reg_wdata,   // register write data
    input  wire logic                        i_reg_wr,         // write strobe
    input  wire logic                        i_reg_rd,         // read strobe
    output logic      [aed_pkg::AED_REG_W-1:0]  o_reg_rdata,   // registered read data
    input  wire logic                        i_sample_tick,    // new output sample this cycle
    input  wire logic                        i_hybrid_mode,    // both sensors active
    input  wire logic signed [aed_pkg::AED_AXIS_W-1:0] i_accel_x, // current x output
    input  wire logic signed [aed_pkg::AED_AXIS_W-1:0] i_accel_y, // current y output
    input  wire logic signed [aed_pkg::AED_AXIS_W-1:0] i_accel_z, // current z output
    input  wire logic                        i_ffmt_condition, // freefall/motion condition
    input  wire logic                        i_ffmt_clear_mode,// freefall/motion clear mode
    output logic                             o_ffmt_event,     // freefall/motion flag
    output logic      [aed_pkg::AED_CNT_W-1:0]  o_ffmt_count,  // freefall/motion count
    output logic                             o_vecm_event      // magnitude change flag
);

    import aed_pkg::*;

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [AED_REG_W-1:0] ffmt_count_limit;  // freefall/motion debounce count
    logic [AED_REG_W-1:0] vecm_cfg;          // magnitude change config
    logic [AED_REG_W-1:0] vecm_ths_h;        // clear mode and threshold msbs
    logic [AED_REG_W-1:0] vecm_ths_l;        // threshold lsbs
    logic [AED_REG_W-1:0] vecm_cnt;          // magnitude debounce count
    logic [AED_REG_W-1:0] init_x_h;          // initial reference bytes
    logic [AED_REG_W-1:0] init_x_l;
    logic [AED_REG_W-1:0] init_y_h;
    logic [AED_REG_W-1:0] init_y_l;
    logic [AED_REG_W-1:0] init_z_h;
    logic [AED_REG_W-1:0] init_z_l;

    // ****************************************************************
    // derived fields
    // ****************************************************************
    logic                         cfg_ele;      // latch enable
    logic                         cfg_initm;    // init source
    logic                         cfg_updm;     // update mode
    logic                         cfg_en;       // function enable
    logic                         vecm_dbcntm;  // magnitude clear mode
    logic [AED_THS_W-1:0]         vecm_ths;     // 13-bit threshold
    logic signed [AED_AXIS_W-1:0] init_x;       // assembled initial references
    logic signed [AED_AXIS_W-1:0] init_y;
    logic signed [AED_AXIS_W-1:0] init_z;

    assign cfg_ele     = vecm_cfg[AED_CFG_ELE_BIT];
    assign cfg_initm   = vecm_cfg[AED_CFG_INITM_BIT];
    assign cfg_updm    = vecm_cfg[AED_CFG_UPDM_BIT];
    assign cfg_en      = vecm_cfg[AED_CFG_EN_BIT];
    assign vecm_dbcntm = vecm_ths_h[AED_THS_DBCNTM_BIT];
    assign vecm_ths    = {vecm_ths_h[4:0], vecm_ths_l};
    assign init_x      = {init_x_h[5:0], init_x_l};
    assign init_y      = {init_y_h[5:0], init_y_l};
    assign init_z      = {init_z_h[5:0], init_z_l};

    // ****************************************************************
    // register writes
    // ****************************************************************
    // undefined bits are masked so they always read back as zero
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            ffmt_count_limit <= AED_RST_BYTE;
            vecm_cfg         <= AED_RST_BYTE;
            vecm_ths_h       <= AED_RST_BYTE;
            vecm_ths_l       <= AED_RST_BYTE;
            vecm_cnt         <= AED_RST_BYTE;
            init_x_h         <= AED_RST_BYTE;
            init_x_l         <= AED_RST_BYTE;
            init_y_h         <= AED_RST_BYTE;
            init_y_l         <= AED_RST_BYTE;
            init_z_h         <= AED_RST_BYTE;
            init_z_l         <= AED_RST_BYTE;
        end
        else if (i_reg_wr)
        begin
            if (i_reg_addr == AED_ADDR_FFMT_COUNT)
                ffmt_count_limit <= i_reg_wdata;
            else if (i_reg_addr == AED_ADDR_VECM_CFG)
                vecm_cfg <= i_reg_wdata & AED_CFG_MASK;
            else if (i_reg_addr == AED_ADDR_VECM_THS_H)
                vecm_ths_h <= i_reg_wdata & AED_THS_H_MASK;
            else if (i_reg_addr == AED_ADDR_VECM_THS_L)
                vecm_ths_l <= i_reg_wdata;
            else if (i_reg_addr == AED_ADDR_VECM_CNT)
                vecm_cnt <= i_reg_wdata;
            else if (i_reg_addr == AED_ADDR_INITX_H)
                init_x_h <= i_reg_wdata & AED_INIT_H_MASK;
            else if (i_reg_addr == AED_ADDR_INITX_L)
                init_x_l <= i_reg_wdata;
            else if (i_reg_addr == AED_ADDR_INITY_H)
                init_y_h <= i_reg_wdata & AED_INIT_H_MASK;
            else if (i_reg_addr == AED_ADDR_INITY_L)
                init_y_l <= i_reg_wdata;
            else if (i_reg_addr == AED_ADDR_INITZ_H)
                init_z_h <= i_reg_wdata & AED_INIT_H_MASK;
            else if (i_reg_addr == AED_ADDR_INITZ_L)
                init_z_l <= i_reg_wdata;
        end
    end

    // ****************************************************************
    // register reads
    // ****************************************************************
    // the working references have no address; only the init bytes read back
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
            o_reg_rdata <= AED_RD_UNMAPPED;
        else if (i_reg_rd)
        begin
            if (i_reg_addr == AED_ADDR_FFMT_COUNT)
                o_reg_rdata <= ffmt_count_limit;
            else if (i_reg_addr == AED_ADDR_VECM_CFG)
                o_reg_rdata <= vecm_cfg;
            else if (i_reg_addr == AED_ADDR_VECM_THS_H)
                o_reg_rdata <= vecm_ths_h;
            else if (i_reg_addr == AED_ADDR_VECM_THS_L)
                o_reg_rdata <= vecm_ths_l;
            else if (i_reg_addr == AED_ADDR_VECM_CNT)
                o_reg_rdata <= vecm_cnt;
            else if (i_reg_addr == AED_ADDR_INITX_H)
                o_reg_rdata <= init_x_h;
            else if (i_reg_addr == AED_ADDR_INITX_L)
                o_reg_rdata <= init_x_l;
            else if (i_reg_addr == AED_ADDR_INITY_H)
                o_reg_rdata <= init_y_h;
            else if (i_reg_addr == AED_ADDR_INITY_L)
                o_reg_rdata <= init_y_l;
            else if (i_reg_addr == AED_ADDR_INITZ_H)
                o_reg_rdata <= init_z_h;
            else if (i_reg_addr == AED_ADDR_INITZ_L)
                o_reg_rdata <= init_z_l;
            else
                o_reg_rdata <= AED_RD_UNMAPPED;
        end
    end

    // ****************************************************************
    // debounce step: every sample, every second one in hybrid mode
    // ****************************************************************
    logic hybrid_phase;  // toggles on each sample while hybrid
    logic step;          // one debounce time step

    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset || !i_hybrid_mode)
            hybrid_phase <= 1'b0;
        else if (i_sample_tick)
            hybrid_phase <= ~hybrid_phase;
    end

    assign step = i_sample_tick && (!i_hybrid_mode || hybrid_phase);

    // ****************************************************************
    // freefall/motion debounce
    // ****************************************************************
    aed_debounce_counter #(
        .CNT_W        (AED_CNT_W)
    ) u_ffmt_counter (
        .i_clk_sys    (i_clk_sys),
        .i_reset      (i_reset),
        .i_step       (step),
        .i_hold_clear (1'b0),
        .i_cond       (i_ffmt_condition),
        .i_clear_mode (i_ffmt_clear_mode),
        .i_limit      (ffmt_count_limit),
        .o_count      (o_ffmt_count),
        .o_active     (o_ffmt_event)
    );

    // ****************************************************************
    // vector-magnitude comparison
    // ****************************************************************
    logic signed [AED_AXIS_W-1:0] ref_x;      // working references, internal only
    logic signed [AED_AXIS_W-1:0] ref_y;
    logic signed [AED_AXIS_W-1:0] ref_z;
    logic [AED_SUM_W-1:0]         dist_sq;    // squared distance
    logic [AED_SUM_W-1:0]         ths_sq;     // squared threshold
    logic                         vecm_cond;  // distance above threshold

    // square of the difference of two 14-bit signed values
    function automatic logic [AED_SUM_W-1:0] sq_diff(
        input logic signed [AED_AXIS_W-1:0] a,
        input logic signed [AED_AXIS_W-1:0] b
    );
        logic signed [AED_AXIS_W:0]     d;
        logic signed [2*AED_AXIS_W+1:0] p;
        d = {a[AED_AXIS_W-1], a} - {b[AED_AXIS_W-1], b};
        p = d * d;
        sq_diff = AED_SUM_W'(p[2*AED_AXIS_W-1:0]);  // zero-extend the 28-bit square
    endfunction : sq_diff

    // no square root: both sides are non-negative, so squaring keeps order
    assign dist_sq = sq_diff(i_accel_x, ref_x) + sq_diff(i_accel_y, ref_y)
                   + sq_diff(i_accel_z, ref_z);
    // operands widened first so the product is formed at full width
    assign ths_sq    = {6'h00, 26'(vecm_ths) * 26'(vecm_ths)};
    assign vecm_cond = dist_sq > ths_sq;

    // ****************************************************************
    // magnitude debounce
    // ****************************************************************
    logic vecm_active;    // debounced magnitude level
    logic vecm_active_q;  // previous level, for trigger edge
    logic vecm_trigger;   // rising edge of debounced level

    aed_debounce_counter #(
        .CNT_W        (AED_CNT_W)
    ) u_vecm_counter (
        .i_clk_sys    (i_clk_sys),
        .i_reset      (i_reset),
        .i_step       (step),
        .i_hold_clear (!cfg_en),
        .i_cond       (vecm_cond),
        .i_clear_mode (vecm_dbcntm),
        .i_limit      (vecm_cnt),
        .o_count      (),
        .o_active     (vecm_active)
    );

    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
            vecm_active_q <= 1'b0;
        else
            vecm_active_q <= vecm_active;
    end

    assign vecm_trigger = vecm_active && !vecm_active_q;

    // ****************************************************************
    // reference load and update
    // ****************************************************************
    logic en_q;        // enable seen last cycle
    logic en_rise;     // function just enabled

    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
            en_q <= 1'b0;
        else
            en_q <= cfg_en;
    end

    assign en_rise = cfg_en && !en_q;

    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            ref_x <= '0;
            ref_y <= '0;
            ref_z <= '0;
        end
        else if ((en_rise || cfg_updm) && cfg_initm && cfg_en)
        begin
            // host-written values; with update mode set they track writes live
            ref_x <= init_x;
            ref_y <= init_y;
            ref_z <= init_z;
        end
        else if (en_rise || (cfg_en && !cfg_updm && vecm_trigger))
        begin
            // capture current output at enable, or at each trigger in update mode 0
            ref_x <= i_accel_x;
            ref_y <= i_accel_y;
            ref_z <= i_accel_z;
        end
        // update mode set without init mode keeps enable-time references
    end

    // ****************************************************************
    // magnitude event flag
    // ****************************************************************
    logic vecm_latched;   // sticky flag for latch mode
    logic src_read;       // host read of the interrupt source

    assign src_read = i_reg_rd && (i_reg_addr == AED_ADDR_INT_SOURCE);

    // a trigger in the same cycle as the clearing read wins
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset || !cfg_en)
            vecm_latched <= 1'b0;
        else if (vecm_trigger)
            vecm_latched <= 1'b1;
        else if (src_read)
            vecm_latched <= 1'b0;
    end

    assign o_vecm_event = cfg_ele ? vecm_latched : vecm_active;

endmodule : aed_event_debounce

// >>> test/aed_event_debounce_props.sv
// port-level checks for the event debounce block
module aed_event_debounce_props (
    input  wire logic       i_clk_sys,         // system clock
    input  wire logic       i_reset,           // synchronous reset
    input  wire logic [7:0] i_reg_addr,        // register address
    input  wire logic       i_reg_rd,          // read strobe
    input  wire logic [7:0] o_reg_rdata,       // read data
    input  wire logic       i_sample_tick,     // sample tick
    input  wire logic       i_hybrid_mode,     // hybrid mode
    input  wire logic       i_ffmt_condition,  // event condition
    input  wire logic       i_ffmt_clear_mode, // clear or decrement
    input  wire logic       o_ffmt_event,      // debounced flag
    input  wire logic [7:0] o_ffmt_count,      // counter value
    input  wire logic       o_vecm_event       // magnitude flag
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    // counter and flag may only move on a sample tick
    a_count_hold: assert property (!i_sample_tick |=> $stable(o_ffmt_count))
        else $error("count moved without a sample tick");
    a_event_hold: assert property (!i_sample_tick |=> $stable(o_ffmt_event))
        else $error("flag moved without a sample tick");
    a_count_stride: assert property (i_sample_tick |=> o_ffmt_count == 8'h00
        || o_ffmt_count == $past(o_ffmt_count) || o_ffmt_count == $past(o_ffmt_count) + 8'h01
        || o_ffmt_count == $past(o_ffmt_count) - 8'h01) else $error("count jumped");
    a_count_clear: assert property (i_sample_tick && !i_hybrid_mode && !i_ffmt_condition
        && i_ffmt_clear_mode |=> o_ffmt_count == 8'h00) else $error("count not cleared");
    a_count_decr: assert property (i_sample_tick && !i_hybrid_mode && !i_ffmt_condition
        && !i_ffmt_clear_mode && o_ffmt_count != 8'h00
        |=> o_ffmt_count == $past(o_ffmt_count) - 8'h01) else $error("count not decremented");
    a_event_rise: assert property ($rose(o_ffmt_event) |-> $past(i_ffmt_condition))
        else $error("flag set without condition");
    a_event_fall: assert property ($fell(o_ffmt_event) |-> o_ffmt_count == 8'h00)
        else $error("flag cleared before count reached zero");
    a_rdata_stands: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read data changed without a read");
    a_unmapped_zero: assert property (i_reg_rd && i_reg_addr > 8'h68 |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    c_ffmt_set: cover property ($rose(o_ffmt_event));
    c_vecm_set: cover property ($rose(o_vecm_event));
    c_vecm_clear: cover property ($fell(o_vecm_event));
endmodule : aed_event_debounce_props

bind aed_event_debounce aed_event_debounce_props i_aed_event_debounce_props (.i_clk_sys,
    .i_reset, .i_reg_addr, .i_reg_rd, .o_reg_rdata, .i_sample_tick, .i_hybrid_mode,
    .i_ffmt_condition, .i_ffmt_clear_mode, .o_ffmt_event, .o_ffmt_count, .o_vecm_event);

// >>> test/aed_host_model.sv
// host side of the register port: strobed byte writes and reads
module aed_host_model (
    input  wire logic       i_clk_sys, // system clock
    output logic      [7:0] o_addr,    // register address
    output logic      [7:0] o_wdata,   // write data
    output logic            o_wr,      // write strobe
    output logic            o_rd,      // read strobe
    input  wire logic [7:0] i_rdata    // read data
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {o_addr, o_wdata, o_wr, o_rd} = 18'h00000;
    // one-cycle write; released data shows the inverse so a stale byte never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk_sys);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask : wr
    // one-cycle read; data is taken once the edge that samples the strobe has landed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk_sys);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk_sys);
        o_rd <= 1'b0;
        #1 d = i_rdata;
    endtask : rd
endmodule : aed_host_model

// >>> test/aed_event_debounce_tb_top.sv
// self-checking bench for the event debounce block
module aed_event_debounce_tb_top import aed_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst = 1, tick = 0, hyb = 0, cond = 0, cmode = 0;
    logic [7:0] addr, wdata, rdata, cnt, d;
    logic wr, rd, ffe, vme;
    logic signed [AED_AXIS_W-1:0] ax = '0;  // all three axes share one stimulus
    int mismatches = 0, total_checks = 0, cyc = 0, mc = 0, lim = 0;
    bit me = 0, ph = 0;  // model flag and hybrid phase
    always #5 clk = ~clk;
    aed_host_model i_aed_host_model (.i_clk_sys(clk), .o_addr(addr), .o_wdata(wdata),
        .o_wr(wr), .o_rd(rd), .i_rdata(rdata));
    aed_event_debounce i_aed_event_debounce (.i_clk_sys(clk), .i_reset(rst),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
        .o_reg_rdata(rdata), .i_sample_tick(tick), .i_hybrid_mode(hyb), .i_accel_x(ax),
        .i_accel_y(ax), .i_accel_z(ax), .i_ffmt_condition(cond), .i_ffmt_clear_mode(cmode),
        .o_ffmt_event(ffe), .o_ffmt_count(cnt), .o_vecm_event(vme));
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // one sample with random condition and mode; the model steps in the same way
    task automatic step(input logic signed [AED_AXIS_W-1:0] a);
        bit c, m, s;
        c = 1'($urandom);
        m = 1'($urandom);
        @(posedge clk);
        tick <= 1'b1;
        cond <= c;
        cmode <= m;
        ax <= a;
        @(posedge clk);
        tick <= 1'b0;
        s = !hyb || ph;  // in hybrid only every second tick is a step
        ph = hyb ? !ph : 1'b0;
        if (s && c)
            mc = (mc < lim) ? mc + 1 : lim;
        else if (s)
            mc = (m || mc == 0) ? 0 : mc - 1;
        if (s && c && mc == lim)
            me = 1;
        else if (s && !c && mc == 0)
            me = 0;
        #1 chk("ffmt count", {8'h00, cnt}, 16'(mc));
        chk("ffmt event", {15'h0000, ffe}, 16'(me));
    endtask : step
    task automatic vstep(input logic signed [AED_AXIS_W-1:0] a, input logic e);
        step(a);
        @(posedge clk);
        #1 chk("vecm event", {15'h0000, vme}, {15'h0000, e});
    endtask : vstep
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            mismatches++;
            wrap_up();
        end
    end
    initial
    begin
        void'($urandom(32'h20bd));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        i_aed_host_model.rd(AED_ADDR_VECM_CFG, d);
        chk("cfg reset", {8'h00, d}, 16'h0000);
        i_aed_host_model.rd(8'h80, d);
        chk("unmapped read", {8'h00, d}, 16'h0000);
        i_aed_host_model.wr(AED_ADDR_FFMT_COUNT, 8'h03);
        lim = 3;
        i_aed_host_model.rd(AED_ADDR_FFMT_COUNT, d);
        chk("ffmt limit", {8'h00, d}, 16'h0003);
        i_aed_host_model.wr(AED_ADDR_VECM_THS_L, 8'h0a);  // threshold 10, squared 100
        i_aed_host_model.wr(AED_ADDR_VECM_CNT, 8'h01);
        // sample ticks here stand for a rate of 400 Hz or less
        i_aed_host_model.wr(AED_ADDR_VECM_CFG, 8'h38);  // init regs, refs track them live
        vstep(20, 1'b1);
        vstep(20, 1'b1);
        vstep(0, 1'b0);
        i_aed_host_model.wr(AED_ADDR_INITX_L, 8'h14);  // live references move to 20
        i_aed_host_model.wr(AED_ADDR_INITY_L, 8'h14);
        i_aed_host_model.wr(AED_ADDR_INITZ_L, 8'h14);
        vstep(0, 1'b1);
        i_aed_host_model.wr(AED_ADDR_VECM_CFG, 8'h78);  // latched flag
        vstep(20, 1'b1);
        vstep(0, 1'b1);
        i_aed_host_model.rd(AED_ADDR_INT_SOURCE, d);
        chk("latched clear", {15'h0000, vme}, 16'h0000);
        i_aed_host_model.wr(AED_ADDR_VECM_CFG, 8'h00);
        @(posedge clk);
        #1 chk("disabled", {15'h0000, vme}, 16'h0000);
        i_aed_host_model.wr(AED_ADDR_VECM_CFG, 8'h08);  // refs from current output
        vstep(20, 1'b1);
        vstep(20, 1'b0);
        repeat (40) step(0);
        @(posedge clk);
        hyb <= 1'b1;
        repeat (30) step(0);
        wrap_up();
    end
endmodule : aed_event_debounce_tb_top
